// ---- hdl/tcpu_top.sv ----
// The implementer's own choice: the AXI4-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
`include "tcpu_cfg.svh"

// Functional notes
// [RL1] Polarity bit 0 makes pin B, C or D active low, 1 active high.
// [RL2] Polarity bits act only in PWM mode; the code applies them in PWM2 as well.
// [RL3] Stop-on-period bit 0 keeps counting after period match, 1 halts there.
// [RL4] Stop-on-period bit acts only in output compare, PWM and PWM2.
// [RL5] Trigger edge field: off, rising, falling, both; honoured only in PWM2.
// [RL6] Bits 3 and 4 of control two read as 1; software writes 0.
// [RL7] Rerouted, pin A follows compare A and C, pin B compare B and D.
// [RL8] Software reroutes by clearing function-select and buffer-mode bits of C and D.
// [RL9] Software keeps C unlike A and D unlike B when rerouting.
// [RL10] PWM drives up to three same-period waves on B, C, D; A stays I/O.
// [RL11] With PWM in use, compare A is the period register.
// [RL12] Count source: f1 to f32, two oscillator clocks or external pin rising edges.
// [RL13] Cycle lasts m+1 counts: n+1 inactive, m-n active.
// [RL14] Writing 1 to the count-start bit starts counting.
// [RL15] Writing 0 to count-start stops; pins and counter hold.
// [RL16] Stop-on-period halts counter at period match; pins keep that match's level.
// [RL17] Matches on compare A to D and counter overflow raise requests.
// [RL18] Counter value is readable anytime and writes load it.
// [RL19] Active level and initial level are set per PWM pin.
// [RL20] External pin serves as interrupt or forced cutoff; buffering and converter trigger exist.
// [RL21] Initial-level bit 0 inactive, 1 active, driven when control one is written.
// [RL22] With buffering, C buffers the next period and D the next change point of B.
// [RL23] A change point equal to the period leaves its pin unchanged at the match.
// [RL24] In PWM the counter returns to zero after the period match.
// [RL25] Change-point match drives active level, period match drives inactive level.
module tcpu_top (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_i,
    // AXI4-Lite write channels.
    input wire logic [11:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    // AXI4-Lite read channels.
    input wire logic [11:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    // Asynchronous pins and clocks.
    input wire logic ext_count_clock_pin_i,
    input wire logic osc_fast_clock_i,
    input wire logic osc_div_clock_i,
    input wire logic ext_trigger_pin_i,
    input wire logic ext_irq_cutoff_pin_n_i,
    // Output pins A to D, bit 0 is A.
    output logic [3:0] out_pin_o,
    output logic [3:0] out_pin_oe_o,
    // Request pulses: matches A to D, overflow, external interrupt.
    output logic [5:0] timer_event_o,
    output logic adc_trigger_o
);

    logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
    logic [1:0] bresp_q, rresp_q;
    logic [31:0] rdata_q;
    logic [7:0] mode_q, ctl1_q, ioc1_q;
    logic [2:0] pol_q;
    logic stop_on_period_sel_q;
    logic [1:0] trig_q;
    logic [15:0] cnt_q;
    logic [15:0] cmp_q [4];
    logic [5:0] stat_q;
    logic [4:0] div_q;
    logic [4:0] sync1_q, sync2_q, sync3_q;
    logic [3:0] match;
    logic [3:0] act_q;
    logic [3:0] oc_lvl_q;
    logic [3:0] pin_d, oe_d;
    logic [5:0] ev;
    logic wr_en, wr_hit, rd_en, rd_hit, tick, run, pwm_like, stop_on_period_sel_mode;
    logic clear_on_a, stop_hit, trig_hit, ext_fall, cutoff;
    logic [31:0] rd_val;
    logic [15:0] wmask;
    tcpu_pkg::tcpu_mode_e mode_sel;

    // Bus write: both halves arrive together, one pulse of ready takes them.
    assign wr_en = awready_q;
    assign rd_en = arready_q;
    assign wmask = {{8{s_axi_wstrb_i[1]}}, {8{s_axi_wstrb_i[0]}}};
    assign wr_hit = (s_axi_awaddr_i[11:2] >= `TCPU_ADDR_MODE >> 2)
        && (s_axi_awaddr_i[11:2] <= `TCPU_ADDR_CMPD >> 2);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            awready_q <= 1'b0;
            wready_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= tcpu_pkg::TCPU_RESP_OKAY;
        end else begin
            awready_q <= s_axi_awvalid_i && s_axi_wvalid_i && !awready_q && !bvalid_q;
            wready_q <= s_axi_awvalid_i && s_axi_wvalid_i && !awready_q && !bvalid_q;
            if (wr_en) begin
                bvalid_q <= 1'b1;
                bresp_q <= wr_hit ? tcpu_pkg::TCPU_RESP_OKAY : tcpu_pkg::TCPU_RESP_SLVERR;
            end else if (s_axi_bready_i) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    assign rd_hit = (s_axi_araddr_i[11:2] >= `TCPU_ADDR_MODE >> 2)
        && (s_axi_araddr_i[11:2] <= `TCPU_ADDR_CMPD >> 2);

    always_comb begin
        rd_val = 32'h0;
        case ({s_axi_araddr_i[11:2], 2'b00})
            `TCPU_ADDR_MODE: rd_val = {24'h0, mode_q};
            `TCPU_ADDR_CTL1: rd_val = {24'h0, ctl1_q};
            `TCPU_ADDR_IOC1: rd_val = {24'h0, ioc1_q};
            `TCPU_ADDR_STAT: rd_val = {26'h0, stat_q};
            `TCPU_ADDR_CTL2: rd_val = {24'h0, trig_q, stop_on_period_sel_q, `TCPU_CTL2_FIXED, pol_q}; // [RL6]
            `TCPU_ADDR_CNT: rd_val = {16'h0, cnt_q}; // [RL18]
            default: begin
                if (rd_hit) begin
                    rd_val = {16'h0, cmp_q[2'(s_axi_araddr_i[11:2] - (`TCPU_ADDR_CMPA >> 2))]};
                end
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0;
            rresp_q <= tcpu_pkg::TCPU_RESP_OKAY;
        end else begin
            arready_q <= s_axi_arvalid_i && !arready_q && !rvalid_q;
            if (rd_en) begin
                rvalid_q <= 1'b1;
                rdata_q <= rd_val;
                rresp_q <= rd_hit ? tcpu_pkg::TCPU_RESP_OKAY : tcpu_pkg::TCPU_RESP_SLVERR;
            end else if (s_axi_rready_i) begin
                rvalid_q <= 1'b0;
            end
        end
    end

    // Two flops on every pin before use; the third only feeds edge detection.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sync1_q <= 5'h1f;
            sync2_q <= 5'h1f;
            sync3_q <= 5'h1f;
        end else begin
            sync1_q <= {ext_irq_cutoff_pin_n_i, ext_trigger_pin_i, osc_div_clock_i,
                osc_fast_clock_i, ext_count_clock_pin_i};
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            div_q <= 5'h0;
        end else begin
            div_q <= div_q + 5'h1;
        end
    end

    // Oscillator sources are sampled, so they must run well below clk_i.
    always_comb begin
        case (ctl1_q[`TCPU_CTL1_SRC_HI:`TCPU_CTL1_SRC_LO]) // [RL12]
            `TCPU_SRC_F1: tick = 1'b1;
            `TCPU_SRC_F2: tick = &div_q[0];
            `TCPU_SRC_F4: tick = &div_q[1:0];
            `TCPU_SRC_F8: tick = &div_q[2:0];
            `TCPU_SRC_F32: tick = &div_q[4:0];
            `TCPU_SRC_EXT: tick = sync2_q[0] && !sync3_q[0];
            `TCPU_SRC_OSCF: tick = sync2_q[1] && !sync3_q[1];
            `TCPU_SRC_OSCD: tick = sync2_q[2] && !sync3_q[2];
            default: tick = 1'b0;
        endcase
    end

    assign mode_sel = tcpu_pkg::tcpu_mode_e'(mode_q[`TCPU_MODE_SEL_HI:`TCPU_MODE_SEL_LO]);
    assign pwm_like = (mode_sel == tcpu_pkg::TCPU_MODE_PWM)
        || (mode_sel == tcpu_pkg::TCPU_MODE_PWM2);
    assign stop_on_period_sel_mode = pwm_like || (mode_sel == tcpu_pkg::TCPU_MODE_OC); // [RL4]
    assign run = mode_q[`TCPU_MODE_START];

    for (genvar k = 0; k < 4; k++) begin : g_match
        assign match[k] = (cnt_q == cmp_q[k]);
        assign ev[k] = run && tick && match[k]; // [RL17]
    end
    assign ev[`TCPU_STAT_OVF] = run && tick && (cnt_q == `TCPU_CNT_MAX) && !clear_on_a;
    assign ext_fall = !sync2_q[4] && sync3_q[4];
    assign ev[`TCPU_STAT_EXT] = ext_fall; // [RL20]

    assign clear_on_a = match[0] && (pwm_like || ctl1_q[`TCPU_CTL1_CLR]); // [RL11] [RL24]
    assign stop_hit = match[0] && stop_on_period_sel_q && stop_on_period_sel_mode; // [RL3] [RL16]
    assign trig_hit = (mode_sel == tcpu_pkg::TCPU_MODE_PWM2) // [RL5]
        && ((trig_q[0] && sync2_q[3] && !sync3_q[3]) || (trig_q[1] && !sync2_q[3] && sync3_q[3]));
    assign cutoff = ioc1_q[`TCPU_IOC1_CUT_EN] && !sync2_q[4]; // [RL20]

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mode_q <= 8'h0;
            ctl1_q <= 8'h0;
            ioc1_q <= `TCPU_IOC1_RESET;
            pol_q <= 3'h0;
            stop_on_period_sel_q <= 1'b0;
            trig_q <= 2'h0;
        end else begin
            if (wr_en && s_axi_wstrb_i[0] && s_axi_awaddr_i == `TCPU_ADDR_MODE) begin
                mode_q <= s_axi_wdata_i[7:0]; // [RL14] [RL15]
            end else if (run && tick && stop_hit) begin
                mode_q[`TCPU_MODE_START] <= 1'b0; // [RL16]
            end else if (trig_hit) begin
                mode_q[`TCPU_MODE_START] <= 1'b1;
            end
            if (wr_en && s_axi_wstrb_i[0] && s_axi_awaddr_i == `TCPU_ADDR_CTL1) begin
                ctl1_q <= s_axi_wdata_i[7:0];
            end
            if (wr_en && s_axi_wstrb_i[0] && s_axi_awaddr_i == `TCPU_ADDR_IOC1) begin
                ioc1_q <= s_axi_wdata_i[7:0];
            end
            if (wr_en && s_axi_wstrb_i[0] && s_axi_awaddr_i == `TCPU_ADDR_CTL2) begin
                pol_q <= s_axi_wdata_i[`TCPU_CTL2_POL_HI:`TCPU_CTL2_POL_LO];
                stop_on_period_sel_q <= s_axi_wdata_i[`TCPU_CTL2_STOP_ON_PERIOD_SEL];
                trig_q <= s_axi_wdata_i[`TCPU_CTL2_TRIG_HI:`TCPU_CTL2_TRIG_LO];
            end
        end
    end

    // A software write beats a count tick in the same cycle.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_q <= 16'h0;
        end else if (wr_en && s_axi_awaddr_i == `TCPU_ADDR_CNT) begin
            cnt_q <= (cnt_q & ~wmask) | (s_axi_wdata_i[15:0] & wmask); // [RL18]
        end else if (run && tick && !stop_hit) begin
            cnt_q <= clear_on_a ? 16'h0 : cnt_q + 16'h1; // [RL13] [RL24]
        end
    end

    for (genvar k = 0; k < 4; k++) begin : g_cmp
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                cmp_q[k] <= `TCPU_CNT_MAX;
            end else if (wr_en && s_axi_awaddr_i == `TCPU_ADDR_CMPA + 12'(4 * k)) begin
                cmp_q[k] <= (cmp_q[k] & ~wmask) | (s_axi_wdata_i[15:0] & wmask);
            end else if (k < 2 && pwm_like && ev[0] && mode_q[`TCPU_MODE_BUF_C + k]) begin
                cmp_q[k] <= cmp_q[(k + 2) % 4]; // [RL22]
            end
        end
    end

    // Flags are write-one-to-clear; a new event wins over the clear.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            stat_q <= 6'h0;
        end else if (wr_en && s_axi_wstrb_i[0] && s_axi_awaddr_i == `TCPU_ADDR_STAT) begin
            stat_q <= (stat_q & ~s_axi_wdata_i[5:0]) | ev;
        end else begin
            stat_q <= stat_q | ev;
        end
    end

    // PWM waveform state: 1 means active phase, on pins B to D.
    assign act_q[0] = 1'b0;
    for (genvar k = 1; k < 4; k++) begin : g_pwm
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                act_q[k] <= 1'b0;
            end else if (wr_en && s_axi_wstrb_i[0] && s_axi_awaddr_i == `TCPU_ADDR_CTL1) begin
                act_q[k] <= s_axi_wdata_i[`TCPU_CTL1_INIT_LO + k - 1]; // [RL19] [RL21]
            end else if (pwm_like && run && tick) begin
                if (match[k] && !match[0]) begin
                    act_q[k] <= 1'b1; // [RL25]
                end else if (match[0] && !match[k]) begin
                    act_q[k] <= 1'b0; // [RL23] [RL25]
                end
            end
        end
    end

    // Output compare levels; rerouting needs function select and buffer bits both 0.
    for (genvar k = 0; k < 2; k++) begin : g_oc
        logic reroute;
        assign reroute = !ioc1_q[k ? `TCPU_IOC1_FSEL_D : `TCPU_IOC1_FSEL_C]
            && !mode_q[`TCPU_MODE_BUF_C + k]; // [RL8]
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                oc_lvl_q[k] <= 1'b0;
                oc_lvl_q[k + 2] <= 1'b0;
            end else if (mode_sel == tcpu_pkg::TCPU_MODE_OC) begin
                if (reroute && ev[k + 2]) begin
                    oc_lvl_q[k] <= 1'b0; // [RL7]
                end else if (ev[k]) begin
                    oc_lvl_q[k] <= reroute ? 1'b1 : !oc_lvl_q[k]; // [RL7]
                end
                if (!reroute && ev[k + 2]) begin
                    oc_lvl_q[k + 2] <= !oc_lvl_q[k + 2];
                end
            end
        end
        assign oe_d[k + 2] = cutoff ? 1'b0 : pwm_like ? (mode_q[`TCPU_MODE_PWM_LO + k + 1]
            && !(k == 0 && mode_q[`TCPU_MODE_BUF_C]))
            : (mode_sel == tcpu_pkg::TCPU_MODE_OC) && !reroute;
    end

    assign oe_d[0] = !cutoff && (mode_sel == tcpu_pkg::TCPU_MODE_OC); // [RL10]
    assign oe_d[1] = cutoff ? 1'b0 : pwm_like ? mode_q[`TCPU_MODE_PWM_LO]
        : (mode_sel == tcpu_pkg::TCPU_MODE_OC);
    for (genvar k = 0; k < 4; k++) begin : g_lvl
        if (k == 0) begin : g_a
            assign pin_d[k] = oc_lvl_q[k];
        end else begin : g_bcd
            assign pin_d[k] = pwm_like ? (act_q[k] ? pol_q[k - 1] : !pol_q[k - 1]) // [RL1] [RL2]
                : oc_lvl_q[k];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            out_pin_o <= 4'h0;
            out_pin_oe_o <= 4'h0;
            timer_event_o <= 6'h0;
            adc_trigger_o <= 1'b0;
        end else begin
            out_pin_o <= pin_d;
            out_pin_oe_o <= oe_d;
            timer_event_o <= ev; // [RL17]
            adc_trigger_o <= pwm_like && ev[0]; // [RL20]
        end
    end

    assign s_axi_awready_o = awready_q;
    assign s_axi_wready_o = wready_q;
    assign s_axi_bvalid_o = bvalid_q;
    assign s_axi_bresp_o = bresp_q;
    assign s_axi_arready_o = arready_q;
    assign s_axi_rvalid_o = rvalid_q;
    assign s_axi_rdata_o = rdata_q;
    assign s_axi_rresp_o = rresp_q;

endmodule
`default_nettype wire

// ---- pkg/tcpu_cfg.svh ----
`ifndef TCPU_CFG_SVH
`define TCPU_CFG_SVH

// Register byte addresses.
`define TCPU_ADDR_MODE 12'h120
`define TCPU_ADDR_CTL1 12'h124
`define TCPU_ADDR_IOC1 12'h128
`define TCPU_ADDR_STAT 12'h12c
`define TCPU_ADDR_CTL2 12'h130
`define TCPU_ADDR_CNT 12'h134
`define TCPU_ADDR_CMPA 12'h138
`define TCPU_ADDR_CMPD 12'h144

// Mode register fields.
`define TCPU_MODE_START 0
`define TCPU_MODE_PWM_LO 1
`define TCPU_MODE_PWM_HI 3
`define TCPU_MODE_BUF_C 4
`define TCPU_MODE_BUF_D 5
`define TCPU_MODE_SEL_LO 6
`define TCPU_MODE_SEL_HI 7

// First control register fields.
`define TCPU_CTL1_INIT_LO 1
`define TCPU_CTL1_INIT_HI 3
`define TCPU_CTL1_SRC_LO 4
`define TCPU_CTL1_SRC_HI 6
`define TCPU_CTL1_CLR 7

// Io control register fields.
`define TCPU_IOC1_CUT_EN 0
`define TCPU_IOC1_FSEL_C 3
`define TCPU_IOC1_FSEL_D 7

// Second control register fields and reset value; io control register reset value.
`define TCPU_CTL2_POL_LO 0
`define TCPU_CTL2_POL_HI 2
`define TCPU_CTL2_STOP_ON_PERIOD_SEL 5
`define TCPU_CTL2_TRIG_LO 6
`define TCPU_CTL2_TRIG_HI 7
`define TCPU_CTL2_FIXED 2'b11
`define TCPU_CTL2_RESET 8'h18
`define TCPU_IOC1_RESET 8'h88

// Status flags: matches a to d, overflow, external interrupt.
`define TCPU_STAT_OVF 4
`define TCPU_STAT_EXT 5
`define TCPU_STAT_W 6

// Count source select codes.
`define TCPU_SRC_F1 3'h0
`define TCPU_SRC_F2 3'h1
`define TCPU_SRC_F4 3'h2
`define TCPU_SRC_F8 3'h3
`define TCPU_SRC_F32 3'h4
`define TCPU_SRC_EXT 3'h5
`define TCPU_SRC_OSCF 3'h6
`define TCPU_SRC_OSCD 3'h7

`define TCPU_CNT_MAX 16'hffff

`endif

// ---- pkg/tcpu_pkg.sv ----
`default_nettype none
package tcpu_pkg;

    typedef enum logic [1:0] {
        TCPU_MODE_TIMER = 2'h0,
        TCPU_MODE_OC = 2'h1,
        TCPU_MODE_PWM = 2'h2,
        TCPU_MODE_PWM2 = 2'h3
    } tcpu_mode_e;

    typedef enum logic [1:0] {
        TCPU_RESP_OKAY = 2'h0,
        TCPU_RESP_SLVERR = 2'h2
    } tcpu_resp_e;

endpackage
`default_nettype wire

// ---- testbench/tcpu_checker.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "tcpu_cfg.svh"
module tcpu_checker (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_i,
    // Bus.
    input wire logic [11:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    input wire logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic s_axi_wvalid_i,
    input wire logic s_axi_wready_o,
    input wire logic [1:0] s_axi_bresp_o,
    input wire logic s_axi_bvalid_o,
    input wire logic s_axi_arvalid_i,
    input wire logic s_axi_arready_o,
    input wire logic s_axi_rvalid_o,
    // Pins and events.
    input wire logic [3:0] out_pin_oe_o,
    input wire logic [5:0] timer_event_o,
    input wire logic adc_trigger_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    // Shadow of the mode field and of the last write address.
    logic pwm_q;
    logic bad_q;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pwm_q <= 1'b0;
            bad_q <= 1'b0;
        end else if (s_axi_awready_o) begin
            if (s_axi_awaddr_i == `TCPU_ADDR_MODE) begin
                pwm_q <= s_axi_wdata_i[7:6] == 2'h2;
            end
            bad_q <= s_axi_awaddr_i < `TCPU_ADDR_MODE || s_axi_awaddr_i > `TCPU_ADDR_CMPD;
        end
    end
    a_ready_pair: assert property (s_axi_awready_o == s_axi_wready_o)
        else $error("write address and data accepted apart");
    a_write_resp: assert property (s_axi_awvalid_i && s_axi_wvalid_i && !s_axi_awready_o
        && !s_axi_bvalid_o |=> s_axi_awready_o ##1 s_axi_bvalid_o)
        else $error("write answer late");
    a_read_resp: assert property (s_axi_arvalid_i && !s_axi_arready_o && !s_axi_rvalid_o
        |=> s_axi_arready_o ##1 s_axi_rvalid_o)
        else $error("read answer late");
    a_resp_code: assert property ($rose(s_axi_bvalid_o) |-> s_axi_bresp_o == (bad_q ? 2'h2 : 2'h0))
        else $error("wrong write response code");
    a_adc_match: assert property (adc_trigger_o |-> timer_event_o[0] && $past(pwm_q))
        else $error("converter trigger without period match");
    a_pin_a_free: assert property (pwm_q [*3] |-> !out_pin_oe_o[0])
        else $error("pin A driven in PWM mode");
    a_ovf_pulse: assert property (timer_event_o[4] |=> !timer_event_o[4])
        else $error("overflow request longer than one cycle");
    a_reset_quiet: assert property ($past(rst_i) |-> timer_event_o == 6'h0 && out_pin_oe_o == 4'h0)
        else $error("outputs active after reset");
endmodule
`default_nettype wire

// ---- testbench/tcpu_load_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module tcpu_load_model (
    // Clock.
    input wire logic clk_i,
    // Pins from the block.
    input wire logic [3:0] pin_i,
    input wire logic [3:0] oe_i,
    // Wire levels and pin B run lengths.
    output logic [3:0] level_o,
    output logic [15:0] hi_len_o,
    output logic [15:0] lo_len_o
);
    // Each load has a pull-down, so an undriven pin reads low.
    assign level_o = pin_i & oe_i;
    logic prev_q = 1'b0;
    logic [15:0] run_q = 16'h0;
    always_ff @(posedge clk_i) begin
        prev_q <= level_o[1];
        run_q <= (level_o[1] != prev_q) ? 16'h1 : run_q + 16'h1;
        if (level_o[1] != prev_q && !level_o[1]) begin
            hi_len_o <= run_q;
        end
        if (level_o[1] != prev_q && level_o[1]) begin
            lo_len_o <= run_q;
        end
    end
endmodule
`default_nettype wire

// ---- testbench/test_tcpu_top.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "tcpu_cfg.svh"
module test_tcpu_top;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [11:0] s_axi_awaddr_i = 12'h0, s_axi_araddr_i = 12'h0;
    logic [31:0] s_axi_wdata_i = 32'h0, s_axi_rdata_o;
    logic [3:0] s_axi_wstrb_i = 4'hf;
    logic s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0, s_axi_bready_i = 1'b0;
    logic s_axi_arvalid_i = 1'b0, s_axi_rready_i = 1'b0, ext_trigger_pin_i = 1'b0;
    logic ext_irq_cutoff_pin_n_i = 1'b1;
    logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
    logic [1:0] s_axi_bresp_o, s_axi_rresp_o;
    logic [3:0] out_pin_o, out_pin_oe_o, lvl;
    logic [5:0] timer_event_o;
    logic adc_trigger_o;
    logic [15:0] hi_len, lo_len, pm, pn;
    logic [65:0] qr[$];
    logic [65:0] e;
    logic [1:0] qb[$];
    logic [31:0] rv [10] = '{32'h0, 32'h0, `TCPU_IOC1_RESET, 32'h0, `TCPU_CTL2_RESET, 32'h0,
        32'hffff, 32'hffff, 32'hffff, 32'hffff};
    int n_mismatch = 0, checked = 0, seed = 76, i;
    always #20 clk_i = ~clk_i;
    // The trigger toggles all along; only PWM2 may react to it.
    always @(posedge clk_i) ext_trigger_pin_i <= ~ext_trigger_pin_i;
    tcpu_top dut (.clk_i, .rst_i, .s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o,
        .s_axi_wdata_i, .s_axi_wstrb_i, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o,
        .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o,
        .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i,
        .ext_count_clock_pin_i(1'b0), .osc_fast_clock_i(1'b0), .osc_div_clock_i(1'b0),
        .ext_trigger_pin_i, .ext_irq_cutoff_pin_n_i, .out_pin_o, .out_pin_oe_o,
        .timer_event_o, .adc_trigger_o);
    tcpu_load_model loads (.clk_i, .pin_i(out_pin_o), .oe_i(out_pin_oe_o), .level_o(lvl),
        .hi_len_o(hi_len), .lo_len_o(lo_len));
    task automatic report_and_stop();
        if (n_mismatch == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [33:0] got, input logic [33:0] exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic tmo();
        n_mismatch++;
        $display("ERROR %0t: wait timed out", $time);
        report_and_stop();
    endtask
    function automatic logic [1:0] resp_of(input logic [11:0] a);
        return (a < `TCPU_ADDR_MODE || a > `TCPU_ADDR_CMPD) ? 2'h2 : 2'h0;
    endfunction
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        int k;
        @(posedge clk_i);
        qb.push_back(resp_of(a));
        s_axi_awaddr_i <= a;
        s_axi_wdata_i <= d;
        s_axi_awvalid_i <= 1'b1;
        s_axi_wvalid_i <= 1'b1;
        s_axi_bready_i <= 1'b1;
        for (k = 0; k < 40; k++) begin
            @(posedge clk_i);
            if (s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
            if (s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
            if (s_axi_bvalid_o) break;
        end
        s_axi_bready_i <= 1'b0;
        if (k == 40) tmo();
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic [31:0] mk = '1);
        int k;
        @(posedge clk_i);
        qr.push_back({resp_of(a), mk, x & mk});
        s_axi_araddr_i <= a;
        s_axi_arvalid_i <= 1'b1;
        s_axi_rready_i <= 1'b1;
        for (k = 0; k < 40; k++) begin
            @(posedge clk_i);
            if (s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
            if (s_axi_rvalid_o) break;
        end
        s_axi_rready_i <= 1'b0;
        if (k == 40) tmo();
    endtask
    task automatic wait_ev(input int b);
        int k;
        for (k = 0; k < 400; k++) begin
            @(posedge clk_i);
            if (timer_event_o[b] === 1'b1) break;
        end
        if (k == 400) tmo();
    endtask
    always @(posedge clk_i) begin
        if (s_axi_bvalid_o && s_axi_bready_i) chk(s_axi_bresp_o, qb.pop_front());
        if (s_axi_rvalid_o && s_axi_rready_i) begin
            e = qr.pop_front();
            chk({s_axi_rresp_o, s_axi_rdata_o & e[63:32]}, {e[65:64], e[31:0]});
        end
    end
    initial begin
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        for (i = 0; i < 10; i++) rd(`TCPU_ADDR_MODE + 12'(4 * i), rv[i]);
        wr(`TCPU_ADDR_CTL2, 32'h07);
        rd(`TCPU_ADDR_CTL2, 32'h1f);
        wr(`TCPU_ADDR_CTL2, 32'he7);
        rd(`TCPU_ADDR_CTL2, 32'hff);
        rd(12'h100, 32'h0);
        wr(12'h200, 32'h1);
        for (i = 0; i < 2; i++) begin
            pm = 16'h6 + 16'($unsigned($random(seed)) % 10);
            pn = 16'($unsigned($random(seed)) % (pm - 16'h1));
            wr(`TCPU_ADDR_MODE, 32'h0);
            wr(`TCPU_ADDR_CNT, 32'h0);
            wr(`TCPU_ADDR_CMPA, pm);
            wr(`TCPU_ADDR_CMPA + 12'h4, pn);
            wr(`TCPU_ADDR_CTL1, 32'h0);
            wr(`TCPU_ADDR_CTL2, i);
            wr(`TCPU_ADDR_MODE, 32'h83);
            repeat (4 * pm + 8) @(posedge clk_i);
            chk(hi_len, i ? pm - pn : pn + 16'h1);
            chk(lo_len, i ? pn + 16'h1 : pm - pn);
            wr(`TCPU_ADDR_MODE, 32'h82);
            wr(`TCPU_ADDR_CNT, 32'h5);
            repeat (20) @(posedge clk_i);
            rd(`TCPU_ADDR_CNT, 32'h5);
            wr(`TCPU_ADDR_CTL2, 32'h20 | i);
            wr(`TCPU_ADDR_MODE, 32'h83);
            repeat (2 * pm + 8) @(posedge clk_i);
            rd(`TCPU_ADDR_CNT, pm);
            rd(`TCPU_ADDR_MODE, 32'h0, 32'h1);
            chk(lvl[1], !i);
        end
        // Timer mode with stop-on-period still set must run past the period match.
        wr(`TCPU_ADDR_MODE, 32'h0);
        wr(`TCPU_ADDR_STAT, 32'h3f);
        wr(`TCPU_ADDR_CNT, 32'hfff0);
        wr(`TCPU_ADDR_CMPA, 32'hfff8);
        wr(`TCPU_ADDR_MODE, 32'h1);
        wait_ev(4);
        rd(`TCPU_ADDR_STAT, 32'h1d, 32'h1d);
        wr(`TCPU_ADDR_MODE, 32'h0);
        // Output compare honours stop-on-period, so it is cleared before rerouting.
        wr(`TCPU_ADDR_CTL2, 32'h0);
        wr(`TCPU_ADDR_IOC1, 32'h0);
        wr(`TCPU_ADDR_CMPA, 32'h28);
        wr(`TCPU_ADDR_CMPA + 12'h8, 32'h50);
        wr(`TCPU_ADDR_CNT, 32'h0);
        wr(`TCPU_ADDR_MODE, 32'h41);
        wait_ev(0);
        repeat (3) @(posedge clk_i);
        chk(out_pin_o[0], 1'b1);
        wait_ev(2);
        repeat (3) @(posedge clk_i);
        chk(out_pin_o[0], 1'b0);
        // A low cutoff pin raises its request and, once enabled, drops the drivers.
        wr(`TCPU_ADDR_IOC1, 32'h1);
        ext_irq_cutoff_pin_n_i <= 1'b0;
        wait_ev(5);
        repeat (3) @(posedge clk_i);
        chk(out_pin_oe_o[0], 1'b0);
        report_and_stop();
    end
endmodule
bind tcpu_top tcpu_checker chk_u (.clk_i, .rst_i, .s_axi_awaddr_i, .s_axi_awvalid_i,
    .s_axi_awready_o, .s_axi_wdata_i, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o,
    .s_axi_bvalid_o, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rvalid_o, .out_pin_oe_o,
    .timer_event_o, .adc_trigger_o);
`default_nettype wire
